// ===== core/role_arb_pkg.sv
// Package for the redundant processor role arbiter.
// Assumes a 100 MHz system clock; all users reference names with the package scope.
package role_arb_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned SEARCH_MS       = 2000;
	localparam int unsigned SEARCH_CYCLES   = SEARCH_MS * 1000 * CLK_MHZ;
	localparam int unsigned BLINK_MS        = 250;
	localparam int unsigned BLINK_CYCLES    = BLINK_MS * 1000 * CLK_MHZ;
	localparam int unsigned POLL_US         = 1000;
	localparam int unsigned POLL_CYCLES     = POLL_US * CLK_MHZ;
	// Link bit rate 1.875 Mbit/s, kept as kbit/s
	localparam int unsigned LINK_KBPS       = 1875;

	// ==========================================================
	// Selector positions and field widths
	localparam logic [3:0]  SEL_MAIN        = 4'h0;
	localparam logic [3:0]  SEL_BACKUP      = 4'h9;
	localparam int unsigned STN_W           = 8;
	localparam int unsigned WORD_W          = 8;
	localparam int unsigned FIFO_DEPTH      = 4;

	// ==========================================================
	// Status word exchanged with the peer
	localparam logic [1:0]  MSG_STATUS      = 2'h1;
	localparam logic [1:0]  MSG_CONFIG      = 2'h2;
	localparam logic [1:0]  MSG_DYNAMIC     = 2'h3;

	typedef struct packed {
		logic       was_active;
		logic       good_cfg;
		logic       first_up;
		logic       is_main;
		logic       is_active;
	} peer_status_t;

	typedef struct packed {
		logic [1:0] kind;
		logic [7:0] data;
	} link_word_t;

	typedef enum logic [2:0] {
		ST_PASSIVE  = 3'b000,
		ST_SEARCH   = 3'b001,
		ST_DECIDE   = 3'b011,
		ST_ACTIVE   = 3'b010,
		ST_IDLE     = 3'b110
	} role_state_t;

	typedef enum logic [1:0] {
		XF_NONE     = 2'b00,
		XF_CONFIG   = 2'b01,
		XF_UPDATE   = 2'b11
	} xfer_state_t;

	localparam logic [STN_W-1:0] STN_RST    = 8'h00;

endpackage : role_arb_pkg

// ===== core/role_arbiter.sv
// Role arbiter for one of a pair of hot-standby controller processors, plus a small FIFO
// that holds outgoing transfer words. Assumes the peer link clock and data are asynchronous.
// Behaviour
// - Unit is always exactly active or passive; passive only polls for takeover.
// - Selector 0 marks main, used to pick active on simultaneous power-up.
// - Selector 9 marks backup, yields active when both held equal roles.
// - Configuration transfer flows active to passive only.
// - Peer serial link carries only configuration transfer traffic.
// - First-powered unit in sequential power-up goes active; it sends config only on a mismatch.
// - After full transfer, sender sends only dynamic variables and settings.
// - Peers exchange status on detection before choosing the sender.
// - Same good configuration: active-role selection applies; active sends only if it got peer status while searching.
// - Mismatch, sequential power-up, first has good config: first sends.
// - All other cases: no unit enters transfer state.
// - Link is full-duplex four-wire at 1.875 Mbit/s; code has one data output, shifted on peer clock falls.
// - Unit enters passive role after power-up before searching.
// - Search 2 s for active peer; none found means become active.
// - Simultaneous power-up restores roles held at last power-down.
// - Equal previous roles: main selector becomes active, backup passive.
// - Active scans remote stations only when configuration matches station.
// - Passive issues periodic polls on its remote port.
// - Active reaching fewer stations than passive causes role swap.
// - Run indicator steady when active, blinks when passive.
// - Config indicator steady when loaded, blinks otherwise.
// - Override indicator shows override modes; passive blinks on bad settings.
// - Active keeps its role unless worse placed than its peer.
`timescale 1ns/1ps

module xfer_fifo #(
	parameter int unsigned WIDTH = 10,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem_q[rd_q];

	function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
		wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : wrap_inc

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wrap_inc(wr_q);
			if (pop) rd_q <= wrap_inc(rd_q);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : xfer_fifo

module role_arbiter #(
	parameter int unsigned SEARCH_CYCLES = role_arb_pkg::SEARCH_CYCLES,
	parameter int unsigned BLINK_CYCLES  = role_arb_pkg::BLINK_CYCLES,
	parameter int unsigned POLL_CYCLES   = role_arb_pkg::POLL_CYCLES,
	parameter int unsigned STN_W         = role_arb_pkg::STN_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	input  wire logic [3:0]       i_role_selector,
	input  wire logic             i_nv_was_active,
	input  wire logic             i_cfg_good,
	input  wire logic             i_cfg_match_peer,
	input  wire logic             i_cfg_match_station,
	input  wire logic             i_override_mode,
	input  wire logic             i_settings_bad,
	input  wire logic [STN_W-1:0] i_reachable_stations_by_active,
	input  wire logic [STN_W-1:0] i_reachable_stations_by_passive,
	input  wire logic             i_peer_present,
	input  wire logic             i_peer_sync_serial_link_clk,
	input  wire logic             i_peer_status_valid,
	input  wire role_arb_pkg::peer_status_t i_peer_status,
	input  wire logic             i_cfg_word_valid,
	input  wire logic [7:0]       i_cfg_word,
	input  wire logic             i_cfg_last,
	output logic                  o_cfg_word_ready,
	input  wire logic             i_dyn_word_valid,
	input  wire logic [7:0]       i_dyn_word,
	output logic                  o_dyn_word_ready,
	output logic                  o_link_data,
	output logic                  o_link_word_taken,
	output logic                  o_is_active,
	output role_arb_pkg::peer_status_t o_own_status,
	output logic                  o_is_sender,
	output logic                  o_xfer_config,
	output logic                  o_xfer_update,
	output logic                  o_scan_enable,
	output logic                  o_poll_pulse,
	output logic                  o_nv_role_write,
	output logic                  o_nv_role_active,
	output logic                  o_led_run,
	output logic                  o_led_config,
	output logic                  o_led_override
);
	// ==========================================================
	// Reset release and input synchronisers
	logic       rst_s1_q;
	logic       rst_n;
	logic [1:0] lclk_s_q;
	logic       lclk_prev_q;
	logic       peer_s1_q;
	logic       peer_q;
	logic       pstv_s1_q;
	logic       pstv_q;
	logic       pstv_prev_q;
	role_arb_pkg::peer_status_t pst_s1_q;
	role_arb_pkg::peer_status_t pst_q;
	role_arb_pkg::peer_status_t peer_st_q;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			lclk_s_q    <= '0;
			lclk_prev_q <= 1'b0;
			peer_s1_q   <= 1'b0;
			peer_q      <= 1'b0;
			pstv_s1_q   <= 1'b0;
			pstv_q      <= 1'b0;
			pstv_prev_q <= 1'b0;
			pst_s1_q    <= '0;
			pst_q       <= '0;
		end else begin
			lclk_s_q    <= {lclk_s_q[0], i_peer_sync_serial_link_clk};
			lclk_prev_q <= lclk_s_q[1];
			peer_s1_q   <= i_peer_present;
			peer_q      <= peer_s1_q;
			pstv_s1_q   <= i_peer_status_valid;
			pstv_q      <= pstv_s1_q;
			pstv_prev_q <= pstv_q;
			pst_s1_q    <= i_peer_status;
			pst_q       <= pst_s1_q;
		end
	end

	// Status is only sampled on the rising edge of its valid, after it has settled
	logic status_evt;
	logic link_fall;
	assign status_evt = pstv_q && !pstv_prev_q;
	assign link_fall  = lclk_prev_q && !lclk_s_q[1];

	// ==========================================================
	// Role state machine
	role_arb_pkg::role_state_t state_q;
	logic [31:0] search_cnt_q;
	logic        first_up_q;
	logic        is_main;
	logic        swap_req;
	logic        swap_arm_q;
	logic        swap_go;

	assign is_main  = (i_role_selector == role_arb_pkg::SEL_MAIN);
	// Backup and any other position are non-main
	assign swap_req = (i_reachable_stations_by_active < i_reachable_stations_by_passive);
	assign swap_go  = swap_req && swap_arm_q;

	function automatic logic decide_active(input logic own_was, input logic peer_was,
		input logic own_main);
		if (own_was != peer_was) decide_active = own_was;
		else decide_active = own_main;
	endfunction : decide_active

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= role_arb_pkg::ST_PASSIVE;
			search_cnt_q <= '0;
			first_up_q   <= 1'b0;
		end else begin
			case (state_q)
				role_arb_pkg::ST_PASSIVE: begin
					search_cnt_q <= '0;
					state_q      <= role_arb_pkg::ST_SEARCH;
				end
				role_arb_pkg::ST_SEARCH: begin
					if (status_evt && pst_q.is_active) begin
						state_q <= role_arb_pkg::ST_IDLE;
					end else if (status_evt) begin
						state_q <= role_arb_pkg::ST_DECIDE;
					end else if (search_cnt_q >= SEARCH_CYCLES - 1) begin
						first_up_q <= 1'b1;
						state_q    <= role_arb_pkg::ST_ACTIVE;
					end else begin
						search_cnt_q <= search_cnt_q + 32'h1;
					end
				end
				role_arb_pkg::ST_DECIDE: begin
					if (decide_active(i_nv_was_active, peer_st_q.was_active, is_main)) begin
						state_q <= role_arb_pkg::ST_ACTIVE;
					end else begin
						state_q <= role_arb_pkg::ST_IDLE;
					end
				end
				role_arb_pkg::ST_ACTIVE: begin
					// Stay active unless worse placed than the peer
					if (peer_q && swap_go) state_q <= role_arb_pkg::ST_IDLE;
				end
				role_arb_pkg::ST_IDLE: begin
					if (!peer_q || swap_go) state_q <= role_arb_pkg::ST_ACTIVE;
				end
				default: state_q <= role_arb_pkg::ST_PASSIVE;
			endcase
		end
	end

	logic active;
	assign active = (state_q == role_arb_pkg::ST_ACTIVE);

	// Counts lag a role change; one swap per rise of the condition stops ping-pong
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			swap_arm_q <= 1'b1;
		end else if (!swap_req) begin
			swap_arm_q <= 1'b1;
		end else if (swap_go && peer_q && (active || state_q == role_arb_pkg::ST_IDLE)) begin
			swap_arm_q <= 1'b0;
		end
	end

	// Status pins change once valid drops, so keep what came with the strobe
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			peer_st_q <= '0;
		end else if (status_evt && state_q == role_arb_pkg::ST_SEARCH) begin
			peer_st_q <= pst_q;
		end
	end

	// ==========================================================
	// Sender selection and transfer phases
	role_arb_pkg::xfer_state_t xf_q;
	logic sender_q;
	logic sender_ok;

	// Case 0 needs equal good configs; case 1 mismatch with a good first unit
	assign sender_ok = active && peer_q && i_cfg_good &&
		(i_cfg_match_peer ? peer_st_q.good_cfg : first_up_q);

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			xf_q     <= role_arb_pkg::XF_NONE;
			sender_q <= 1'b0;
		end else begin
			sender_q <= sender_ok;
			case (xf_q)
				role_arb_pkg::XF_NONE: begin
					if (sender_ok) xf_q <= role_arb_pkg::XF_CONFIG;
				end
				role_arb_pkg::XF_CONFIG: begin
					if (!sender_ok) xf_q <= role_arb_pkg::XF_NONE;
					else if (i_cfg_word_valid && o_cfg_word_ready && i_cfg_last)
						xf_q <= role_arb_pkg::XF_UPDATE;
				end
				role_arb_pkg::XF_UPDATE: begin
					if (!sender_ok) xf_q <= role_arb_pkg::XF_NONE;
				end
				default: xf_q <= role_arb_pkg::XF_NONE;
			endcase
		end
	end

	// ==========================================================
	// Outgoing link words through the FIFO, shifted out on link clock falls
	role_arb_pkg::link_word_t fin;
	role_arb_pkg::link_word_t fout;
	logic fin_valid;
	logic fin_ready;
	logic fout_valid;
	logic fout_ready;
	logic in_cfg;
	logic in_upd;

	assign in_cfg    = (xf_q == role_arb_pkg::XF_CONFIG);
	assign in_upd    = (xf_q == role_arb_pkg::XF_UPDATE);
	// Only transfer traffic ever reaches the link
	assign fin_valid = (in_cfg && i_cfg_word_valid) || (in_upd && i_dyn_word_valid);
	assign fin.kind  = in_cfg ? role_arb_pkg::MSG_CONFIG : role_arb_pkg::MSG_DYNAMIC;
	assign fin.data  = in_cfg ? i_cfg_word : i_dyn_word;
	assign o_cfg_word_ready = in_cfg && fin_ready;
	assign o_dyn_word_ready = in_upd && fin_ready;

	xfer_fifo #(
		.WIDTH ($bits(role_arb_pkg::link_word_t)),
		.DEPTH (role_arb_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst_n     (rst_n),
		.i_in_valid  (fin_valid),
		.o_in_ready  (fin_ready),
		.i_in_data   (fin),
		.o_out_valid (fout_valid),
		.i_out_ready (fout_ready),
		.o_out_data  (fout)
	);

	logic [9:0] sh_q;
	logic [3:0] bits_q;
	logic       taken_q;
	assign fout_ready = (bits_q == 4'h0);

	// Link bit pacing follows the peer clock, nominally 1.875 Mbit/s
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_q    <= '0;
			bits_q  <= 4'h0;
			taken_q <= 1'b0;
		end else begin
			taken_q <= fout_valid && fout_ready;
			if (fout_valid && fout_ready) begin
				sh_q   <= fout;
				bits_q <= 4'ha;
			end else if (link_fall && bits_q != 4'h0) begin
				sh_q   <= {sh_q[8:0], 1'b0};
				bits_q <= bits_q - 4'h1;
			end
		end
	end

	// ==========================================================
	// Remote station scan, polling, indicators, role retention
	logic [31:0] poll_cnt_q;
	logic [31:0] blink_cnt_q;
	logic        blink_q;
	logic        poll_q;
	logic        active_prev_q;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_cnt_q <= '0;
			poll_q     <= 1'b0;
		end else begin
			poll_q <= 1'b0;
			if (active || poll_cnt_q >= POLL_CYCLES - 1) begin
				poll_cnt_q <= '0;
				poll_q     <= !active;
			end else begin
				poll_cnt_q <= poll_cnt_q + 32'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q >= BLINK_CYCLES - 1) begin
			blink_cnt_q <= '0;
			blink_q     <= !blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_is_active      <= 1'b0;
			o_own_status     <= '0;
			o_is_sender      <= 1'b0;
			o_xfer_config    <= 1'b0;
			o_xfer_update    <= 1'b0;
			o_scan_enable    <= 1'b0;
			o_poll_pulse     <= 1'b0;
			o_nv_role_write  <= 1'b0;
			o_nv_role_active <= 1'b0;
			o_led_run        <= 1'b0;
			o_led_config     <= 1'b0;
			o_led_override   <= 1'b0;
			o_link_data      <= 1'b0;
			o_link_word_taken <= 1'b0;
			active_prev_q    <= 1'b0;
		end else begin
			active_prev_q    <= active;
			o_is_active      <= active;
			o_own_status     <= '{was_active: i_nv_was_active, good_cfg: i_cfg_good,
				first_up: first_up_q, is_main: is_main, is_active: active};
			o_is_sender      <= sender_q;
			o_xfer_config    <= in_cfg;
			o_xfer_update    <= in_upd;
			o_scan_enable    <= active && i_cfg_match_station;
			o_poll_pulse     <= poll_q;
			// Store each role change so the next power-up can restore it
			o_nv_role_write  <= active != active_prev_q;
			o_nv_role_active <= active;
			o_led_run        <= active ? 1'b1 : blink_q;
			o_led_config     <= i_cfg_good ? 1'b1 : blink_q;
			o_led_override   <= (!active && i_settings_bad) ? blink_q : i_override_mode;
			o_link_data      <= sh_q[9];
			o_link_word_taken <= taken_q;
		end
	end

	// ==========================================================
	// Checks
	property p_scan_only_active;
		@(posedge i_clk) disable iff (!rst_n)
		o_scan_enable |-> $past(active) && $past(i_cfg_match_station);
	endproperty
	a_scan_only_active: assert property (p_scan_only_active)
		else $error("scan enabled while not active or mismatched");

	property p_no_xfer_on_bad_cfg;
		@(posedge i_clk) disable iff (!rst_n)
		!i_cfg_good |=> xf_q == role_arb_pkg::XF_NONE;
	endproperty
	a_no_xfer_on_bad_cfg: assert property (p_no_xfer_on_bad_cfg)
		else $error("transfer entered with bad configuration");

	property p_xfer_only_active;
		@(posedge i_clk) disable iff (!rst_n)
		xf_q != role_arb_pkg::XF_NONE |-> $past(active);
	endproperty
	a_xfer_only_active: assert property (p_xfer_only_active)
		else $error("passive unit sending configuration");

	property p_reset_passive;
		@(posedge i_clk) disable iff (!rst_n)
		$rose(rst_n) |-> state_q == role_arb_pkg::ST_PASSIVE;
	endproperty
	a_reset_passive: assert property (p_reset_passive)
		else $error("unit not passive after reset");

	property p_swap_down;
		@(posedge i_clk) disable iff (!rst_n)
		active && peer_q && swap_go |=> !active;
	endproperty
	a_swap_down: assert property (p_swap_down)
		else $error("active unit did not yield to better peer");

	property p_keep_active;
		@(posedge i_clk) disable iff (!rst_n)
		active && !swap_req |=> active;
	endproperty
	a_keep_active: assert property (p_keep_active)
		else $error("active role dropped without cause");

	property p_run_led;
		@(posedge i_clk) disable iff (!rst_n)
		active |=> o_led_run;
	endproperty
	a_run_led: assert property (p_run_led)
		else $error("run indicator not steady while active");

	sequence s_cfg_last;
		in_cfg && i_cfg_word_valid && o_cfg_word_ready && i_cfg_last && sender_ok;
	endsequence
	property p_update_phase;
		@(posedge i_clk) disable iff (!rst_n)
		s_cfg_last |=> xf_q == role_arb_pkg::XF_UPDATE ##1 o_xfer_update;
	endproperty
	a_update_phase: assert property (p_update_phase)
		else $error("update phase not entered after configuration");

	property p_no_poll_active;
		@(posedge i_clk) disable iff (!rst_n)
		o_poll_pulse |-> !$past(active, 2);
	endproperty
	a_no_poll_active: assert property (p_no_poll_active)
		else $error("active unit issued a poll");
endmodule : role_arbiter

// ===== verification/peer_model.sv
// Behavioural peer processor on the far side of the arbiter's peer link.
// Assumes the bench calls its tasks just after a rising edge of i_clk.
`timescale 1ns/1ps

module peer_model (
	input  wire logic                  i_clk,
	output logic                       o_present,
	output logic                       o_link_clk,
	output logic                       o_status_valid,
	output role_arb_pkg::peer_status_t o_status
);
	initial begin
		o_present      = 1'b0;
		o_link_clk     = 1'b0;
		o_status_valid = 1'b0;
		o_status       = '0;
	end

	// ==========================================================
	// Presence and status exchange
	task automatic set_present(input logic v);
		o_present = v;
	endtask : set_present

	// Data is set well ahead of valid and kept well past it, then inverted
	task automatic send_status(input role_arb_pkg::peer_status_t st, input int unsigned dly);
		repeat (dly) @(posedge i_clk);
		#1 o_status = st;
		repeat (3) @(posedge i_clk);
		#1 o_status_valid = 1'b1;
		repeat (8) @(posedge i_clk);
		#1 o_status_valid = 1'b0;
		repeat (3) @(posedge i_clk);
		#1 o_status = ~st;
	endtask : send_status

	// ==========================================================
	// Link clock runs only inside a frame and rests low between frames
	task automatic link_frame(input int unsigned bits);
		repeat (bits) begin
			#80 o_link_clk = 1'b1;
			#80 o_link_clk = 1'b0;
		end
	endtask : link_frame
endmodule : peer_model

// ===== verification/testbench.sv
// Self-checking bench for the role arbiter, one task per scenario.
// Assumes shortened search, blink and poll counts handed to the design.
`timescale 1ns/1ps

module testbench;
	localparam int unsigned SEARCH = 200;
	localparam int unsigned BLINK  = 20;
	localparam int unsigned POLL   = 50;

	logic i_clk, i_arst_n, nv, cfg_good, match_peer, match_stn, ovr, sbad;
	logic cfg_valid, cfg_last, dyn_valid, cfg_ready, dyn_ready, link_data, taken;
	logic is_active, is_sender, xf_cfg, xf_upd, scan, poll, nv_wr, nv_act;
	logic led_run, led_cfg, led_ovr, present, lclk, sv;
	logic [3:0] sel;
	logic [7:0] by_act, by_pas, cfg_word, dyn_word;
	role_arb_pkg::peer_status_t st, own;
	int unsigned failures, cmp_count, taken_cnt, cyc;

	role_arbiter #(.SEARCH_CYCLES(SEARCH), .BLINK_CYCLES(BLINK), .POLL_CYCLES(POLL)) dut (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_role_selector(sel), .i_nv_was_active(nv),
		.i_cfg_good(cfg_good), .i_cfg_match_peer(match_peer), .i_cfg_match_station(match_stn),
		.i_override_mode(ovr), .i_settings_bad(sbad), .i_reachable_stations_by_active(by_act),
		.i_reachable_stations_by_passive(by_pas), .i_peer_present(present),
		.i_peer_sync_serial_link_clk(lclk), .i_peer_status_valid(sv), .i_peer_status(st),
		.i_cfg_word_valid(cfg_valid), .i_cfg_word(cfg_word), .i_cfg_last(cfg_last),
		.o_cfg_word_ready(cfg_ready), .i_dyn_word_valid(dyn_valid), .i_dyn_word(dyn_word),
		.o_dyn_word_ready(dyn_ready), .o_link_data(link_data), .o_link_word_taken(taken),
		.o_is_active(is_active), .o_own_status(own), .o_is_sender(is_sender),
		.o_xfer_config(xf_cfg), .o_xfer_update(xf_upd), .o_scan_enable(scan),
		.o_poll_pulse(poll), .o_nv_role_write(nv_wr), .o_nv_role_active(nv_act),
		.o_led_run(led_run), .o_led_config(led_cfg), .o_led_override(led_ovr));

	peer_model peer (.i_clk(i_clk), .o_present(present), .o_link_clk(lclk),
		.o_status_valid(sv), .o_status(st));

	always #5 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		if (taken === 1'b1) taken_cnt <= taken_cnt + 1;
	end

	// Run length is a few thousand cycles; the ceiling leaves ample room
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			conclude();
		end
	end

	// ==========================================================
	// Shared helpers
	task automatic step(input int unsigned n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic power(input logic nv_in, input logic [3:0] sel_in);
		i_arst_n = 1'b0;
		nv = nv_in;
		sel = sel_in;
		step(2);
		i_arst_n = 1'b1;
		step(6);
	endtask : power

	function automatic logic led(input int unsigned k);
		return (k == 0) ? led_run : ((k == 1) ? led_cfg : led_ovr);
	endfunction : led

	task automatic toggles(input int unsigned k, input int unsigned n, output int unsigned t);
		logic p;
		t = 0;
		p = led(k);
		repeat (n) begin
			step(1);
			if (led(k) !== p) t++;
			p = led(k);
		end
	endtask : toggles

	// Samples one 10-bit word, most significant bit first, at link rises
	task automatic get_word(output logic [9:0] w);
		fork
			peer.link_frame(10);
			repeat (10) begin
				@(posedge lclk);
				w = {w[8:0], link_data};
			end
		join
		step(5);
	endtask : get_word

	task automatic send(input logic dyn, input logic [7:0] d, input logic last);
		int unsigned k;
		dyn_valid = dyn;
		cfg_valid = ~dyn;
		dyn_word = d;
		cfg_word = d;
		cfg_last = last;
		for (k = 0; k < 20; k++) begin
			@(posedge i_clk);
			if ((dyn ? dyn_ready : cfg_ready) === 1'b1) break;
		end
		#1;
		dyn_valid = 1'b0;
		cfg_valid = 1'b0;
		cfg_last = 1'b0;
	endtask : send

	// ==========================================================
	// Scenarios
	task automatic t_search;
		int unsigned t;
		cfg_good = 1'b1;
		match_stn = 1'b1;
		ovr = 1'b1;
		i_arst_n = 1'b0;
		step(1);
		check(is_active, 0);
		power(1'b0, role_arb_pkg::SEL_MAIN);
		check(is_active, 0);
		step(SEARCH - 30);
		check(is_active, 0);
		step(60);
		check(is_active, 1);
		check(scan, 1);
		check(nv_act, 1);
		check(own, 5'b01111);
		check(led_ovr, 1);
		toggles(0, 60, t);
		check(t, 0);
		toggles(1, 60, t);
		check(t, 0);
		match_stn = 1'b0;
		step(5);
		check(scan, 0);
		$display("test search done");
	endtask : t_search

	task automatic t_passive;
		int unsigned t, n;
		cfg_good = 1'b0;
		sbad = 1'b1;
		ovr = 1'b0;
		peer.set_present(1'b1);
		power(1'b1, role_arb_pkg::SEL_MAIN);
		peer.send_status(role_arb_pkg::peer_status_t'(5'b01001), 2);
		step(SEARCH + 20);
		check(is_active, 0);
		n = 0;
		repeat (200) begin
			step(1);
			if (poll === 1'b1) n++;
		end
		check(n, 200 / POLL);
		for (int k = 0; k < 3; k++) begin
			toggles(k, 100, t);
			check(t, 100 / BLINK);
		end
		sbad = 1'b0;
		cfg_good = 1'b1;
		$display("test passive done");
	endtask : t_passive

	// Columns: stored role, peer stored role, backup selector, expected role
	task automatic t_decide;
		localparam logic [5:0] NVT = 6'b000111;
		localparam logic [5:0] PWT = 6'b001110;
		localparam logic [5:0] BKT = 6'b011011;
		localparam logic [5:0] EXT = 6'b100101;
		for (int i = 0; i < 6; i++) begin
			power(NVT[i], BKT[i] ? role_arb_pkg::SEL_BACKUP : role_arb_pkg::SEL_MAIN);
			peer.send_status(role_arb_pkg::peer_status_t'({PWT[i], 4'b1000}), 0);
			step(20);
			check(is_active, EXT[i]);
		end
		$display("test decide done");
	endtask : t_decide

	task automatic t_swap;
		int unsigned w;
		by_act = 8'h05;
		by_pas = 8'h05;
		power(1'b1, role_arb_pkg::SEL_MAIN);
		peer.send_status(role_arb_pkg::peer_status_t'(5'b11000), 0);
		step(60);
		check(is_active, 1);
		by_act = 8'h04;
		w = 0;
		repeat (10) begin
			step(1);
			if (nv_wr === 1'b1) w++;
		end
		check(is_active, 0);
		check(w, 1);
		check(nv_act, 0);
		by_act = 8'h05;
		step(1);
		by_pas = 8'h06;
		step(3);
		check(is_active, 1);
		by_pas = 8'h05;
		$display("test swap done");
	endtask : t_swap

	task automatic t_nosend;
		for (int i = 0; i < 2; i++) begin
			match_peer = i[0];
			cfg_good = ~i[0];
			power(1'b1, role_arb_pkg::SEL_MAIN);
			peer.send_status(role_arb_pkg::peer_status_t'(5'b11000), 0);
			step(20);
			check(is_active, 1);
			check(xf_cfg, 0);
			check(is_sender, 0);
		end
		cfg_good = 1'b1;
		peer.set_present(1'b0);
		match_peer = 1'b0;
		power(1'b0, role_arb_pkg::SEL_BACKUP);
		step(SEARCH + 20);
		peer.set_present(1'b1);
		step(10);
		check(xf_cfg, 1);
		check(is_sender, 1);
		$display("test sender choice done");
	endtask : t_nosend

	task automatic t_xfer;
		int unsigned n;
		logic [9:0] w;
		match_peer = 1'b1;
		power(1'b1, role_arb_pkg::SEL_MAIN);
		peer.send_status(role_arb_pkg::peer_status_t'(5'b11000), 0);
		step(20);
		check(is_sender, 1);
		check(xf_cfg, 1);
		taken_cnt = 0;
		cfg_valid = 1'b1;
		cfg_word = 8'ha5;
		n = 0;
		repeat (12) begin
			@(posedge i_clk);
			if (cfg_ready === 1'b1) n++;
			#1 cfg_word = 8'ha5 + n[7:0];
		end
		cfg_valid = 1'b0;
		check(n, role_arb_pkg::FIFO_DEPTH + 1);
		check(taken_cnt, 1);
		get_word(w);
		check(w, {role_arb_pkg::MSG_CONFIG, 8'ha5});
		for (int k = 1; k < 5; k++) begin
			get_word(w);
			check(w, {role_arb_pkg::MSG_CONFIG, 8'ha5 + k[7:0]});
		end
		check(taken_cnt, role_arb_pkg::FIFO_DEPTH + 1);
		send(1'b0, 8'h3c, 1'b1);
		step(3);
		check(xf_upd, 1);
		check(xf_cfg, 0);
		check(cfg_ready, 0);
		send(1'b1, 8'h5a, 1'b0);
		get_word(w);
		check(w, {role_arb_pkg::MSG_CONFIG, 8'h3c});
		get_word(w);
		check(w, {role_arb_pkg::MSG_DYNAMIC, 8'h5a});
		$display("test transfer done");
	endtask : t_xfer

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		i_clk = 1'b0;
		i_arst_n = 1'b0;
		{nv, cfg_good, match_peer, match_stn, ovr, sbad} = '0;
		{cfg_valid, cfg_last, dyn_valid} = '0;
		sel = role_arb_pkg::SEL_MAIN;
		by_act = 8'h00;
		by_pas = 8'h00;
		cfg_word = 8'h00;
		dyn_word = 8'h00;
		t_search();
		t_passive();
		t_decide();
		t_swap();
		t_nosend();
		t_xfer();
		conclude();
	end
endmodule : testbench
